// ### hdl/timer_pkg.sv
// Purpose: Shared constants and carriers of the compare/capture timer block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register indices are byte addresses divided by four

package timer_pkg;

  // ----------------------------------------------------------------
  // Register indices and address decode
  // ----------------------------------------------------------------
  localparam int          ADDR_W               = 8;
  localparam logic [7:0]  IDX_TIMER_CONTROL    = 8'h12;
  localparam logic [7:0]  IDX_EVENT_FLAGS      = 8'h13;
  localparam logic [7:0]  IDX_CAPTURE_HIGH     = 8'h14;
  localparam logic [7:0]  IDX_CAPTURE_LOW      = 8'h15;
  localparam logic [7:0]  IDX_COMPARE_HIGH     = 8'h16;
  localparam logic [7:0]  IDX_COMPARE_LOW      = 8'h17;
  localparam logic [7:0]  IDX_COUNTER_HIGH     = 8'h18;
  localparam logic [7:0]  IDX_COUNTER_LOW      = 8'h19;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          CTL_CAPTURE_IRQ_BIT  = 7;
  localparam int          CTL_COMPARE_IRQ_BIT  = 6;
  localparam int          CTL_WRAP_IRQ_BIT     = 5;
  localparam int          CTL_EDGE_BIT         = 1;
  localparam int          CTL_LEVEL_BIT        = 0;
  localparam int          FLG_CAPTURE_BIT      = 7;
  localparam int          FLG_COMPARE_BIT      = 6;
  localparam int          FLG_WRAP_BIT         = 5;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [15:0] COUNTER_RESET        = 16'hfffc;
  localparam logic [15:0] COUNTER_ALL_ONES     = 16'hffff;
  localparam logic [1:0]  PRESCALE_LAST        = 2'h3;
  localparam int          PRESCALE_DIVIDE      = 4;

  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic wrap_irq_enable;
    logic compare_output_level;
  } control_type;

  typedef struct packed {
    logic capture_event_flag;
    logic compare_match_flag;
    logic counter_wrap_flag;
  } flags_type;

endpackage : timer_pkg

// ### hdl/timer_output_compare_status.sv
// Purpose: 16-bit free-running timer with output compare, capture, flags
// Assumes: pclk is the internal bus clock; stop_mode freezes the counter
// Notes:   APB answers with no wait state; flags survive reset by design
//
// Operation
// R1: Compare count once per four-clock tick
// R2: Match drives pin to selected level
// R3: Compare bytes read/write, reset keeps them
// R4: High byte write blocks matches until low
// R5: Compare flag clears: status read, low access
// R6: Level transferred on every match
// R7: Software updates compare in safe order
// R8: Reset clears control except edge select
// R9: Capture enable gates capture interrupt
// R10: Compare enable gates match interrupt, reset clears
// R11: Wrap enable gates wrap interrupt, reset clears
// R12: Edge select rising/falling, reset keeps it
// R13: Software selects rising for comparator modes
// R14: Level bit high/low, reset clears
// R15: Status writes ignored, reset keeps flags
// R16: Capture flag sets on edge, clears by sequence
// R17: Compare flag sets on count equality
// R18: Wrap flag sets on rollover, clears by sequence
// R19: Wait mode: counts normally, may interrupt
// R20: Stop holds count; reset presets it
// R21: Stop-mode edge arms capture, shown after wake
// R22: Halt mode behaves as wait
// R23: Counter presets, advances every four clocks
// R24: Capture copies counter; high read blocks
// R25: Wrap interrupt only with its enable
// R26: One interrupt: OR of gated flags
// R27: Control and status layout chosen here

`timescale 1ns/1ps

module timer_output_compare_status
  import timer_pkg::*;
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [timer_pkg::ADDR_W+1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic                            pready,
  output logic [31:0]                     prdata,
  output logic                            pslverr,
  input  wire logic                       stop_mode,
  input  wire logic                       capture_from_comparator,
  input  wire logic                       capture_input_pin,
  input  wire logic                       comparator_two_flag,
  output logic                            compare_output_pin,
  output logic                            timer_irq
);
  import timer_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W+1:0] a, input logic [7:0] idx);
    hit = (a[ADDR_W+1:2] == idx) && (a[1:0] == 2'h0);
  endfunction : hit

  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        access;
  logic        setup;
  logic        wr_acc;
  logic        rd_acc;

  assign setup  = psel && !penable && !pready_q;
  assign access = psel && penable && pready_q;
  assign wr_acc = access && pwrite;
  assign rd_acc = access && !pwrite;

  logic sel_ctl;
  logic sel_flg;
  logic sel_caph;
  logic sel_capl;
  logic sel_cmph;
  logic sel_cmpl;
  logic sel_cnth;
  logic sel_cntl;
  logic sel_any;

  assign sel_ctl  = hit(paddr, IDX_TIMER_CONTROL);
  assign sel_flg  = hit(paddr, IDX_EVENT_FLAGS);
  assign sel_caph = hit(paddr, IDX_CAPTURE_HIGH);
  assign sel_capl = hit(paddr, IDX_CAPTURE_LOW);
  assign sel_cmph = hit(paddr, IDX_COMPARE_HIGH);
  assign sel_cmpl = hit(paddr, IDX_COMPARE_LOW);
  assign sel_cnth = hit(paddr, IDX_COUNTER_HIGH);
  assign sel_cntl = hit(paddr, IDX_COUNTER_LOW);
  assign sel_any  = sel_ctl | sel_flg | sel_caph | sel_capl |
                    sel_cmph | sel_cmpl | sel_cnth | sel_cntl;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  control_type ctrl_q;
  logic        edge_select_q;
  flags_type   flags_q;
  flags_type   armed_q;
  logic [15:0] compare_q;
  logic [15:0] counter_q;
  logic [15:0] capture_q;
  logic [7:0]  low_latch_q;
  logic        low_latched_q;
  logic        compare_inhibit_q;
  logic        capture_block_q;
  logic [1:0]  prescale_q;
  logic        pin_q;
  logic        irq_q;
  logic        pending_q;
  logic [15:0] pending_value_q;

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  logic tick;
  logic wrap;
  assign tick = !stop_mode && (prescale_q == PRESCALE_LAST);
  assign wrap = tick && (counter_q == COUNTER_ALL_ONES);

  // R23: prescaled count
  // R20: stop holds count
  // R19: wait keeps counting
  // R22: halt same as wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_q <= 2'h0;
      counter_q  <= COUNTER_RESET;
    end else if (!stop_mode) begin
      prescale_q <= prescale_q + 2'h1;
      if (tick) begin
        counter_q <= counter_q + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  logic match;
  // R1: compare per tick
  // R4: inhibit after high write
  assign match = tick && !compare_inhibit_q && (counter_q == compare_q);

  // R3: compare storage, no reset
  always_ff @(posedge pclk) begin
    if (wr_acc && sel_cmph) begin
      compare_q[15:8] <= pwdata[7:0];
    end
    if (wr_acc && sel_cmpl) begin
      compare_q[7:0] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_inhibit_q <= 1'b0;
    end else if (wr_acc && sel_cmph) begin
      compare_inhibit_q <= 1'b1;
    end else if (wr_acc && sel_cmpl) begin
      compare_inhibit_q <= 1'b0;
    end
  end

  // R2: drive pin on match
  // R6: regardless of flag
  // R14: level high or low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else if (match) begin
      pin_q <= ctrl_q.compare_output_level;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // R8: reset clears control
  // R10: compare enable
  // R11: wrap enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
    end else if (wr_acc && sel_ctl) begin
      ctrl_q.capture_irq_enable   <= pwdata[CTL_CAPTURE_IRQ_BIT];
      ctrl_q.compare_irq_enable   <= pwdata[CTL_COMPARE_IRQ_BIT];
      ctrl_q.wrap_irq_enable      <= pwdata[CTL_WRAP_IRQ_BIT];
      ctrl_q.compare_output_level <= pwdata[CTL_LEVEL_BIT];
    end
  end

  // R12: edge select kept across reset
  always_ff @(posedge pclk) begin
    if (wr_acc && sel_ctl) begin
      edge_select_q <= pwdata[CTL_EDGE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Capture source synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_sync_q;
  logic [2:0] cmp_sync_q;
  logic       pin_stable_q;
  logic       cmp_stable_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_q <= 3'h0;
      cmp_sync_q <= 3'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], capture_input_pin};
      cmp_sync_q <= {cmp_sync_q[1:0], comparator_two_flag};
    end
  end

  // Change counts only once stages two and three agree
  logic pin_agree;
  logic cmp_agree;
  assign pin_agree = (pin_sync_q[1] == pin_sync_q[2]);
  assign cmp_agree = (cmp_sync_q[1] == cmp_sync_q[2]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_stable_q <= 1'b0;
      cmp_stable_q <= 1'b0;
    end else begin
      if (pin_agree) begin
        pin_stable_q <= pin_sync_q[2];
      end
      if (cmp_agree) begin
        cmp_stable_q <= cmp_sync_q[2];
      end
    end
  end

  logic src_old;
  logic src_new;
  logic src_agree;
  logic cap_edge;
  assign src_old   = capture_from_comparator ? cmp_stable_q : pin_stable_q;
  assign src_new   = capture_from_comparator ? cmp_sync_q[2] : pin_sync_q[2];
  assign src_agree = capture_from_comparator ? cmp_agree : pin_agree;
  // R12: polarity choice
  assign cap_edge  = src_agree && (src_old != src_new) && (src_new == edge_select_q);

  // ----------------------------------------------------------------
  // Capture datapath
  // ----------------------------------------------------------------
  logic cap_take;
  logic cap_release;
  // R24: high read blocks captures
  assign cap_take    = cap_edge && !stop_mode && !capture_block_q;
  // R21: armed edge shows after wake
  assign cap_release = pending_q && !stop_mode && !capture_block_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_block_q <= 1'b0;
    end else if (rd_acc && sel_caph) begin
      capture_block_q <= 1'b1;
    end else if (rd_acc && sel_capl) begin
      capture_block_q <= 1'b0;
    end
  end

  // R21: reset drops an armed edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_q <= 1'b0;
    end else if (cap_edge && stop_mode && !pending_q) begin
      pending_q <= 1'b1;
    end else if (cap_release) begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk) begin
    if (cap_edge && stop_mode && !pending_q) begin
      pending_value_q <= counter_q;
    end
  end

  // R24: copy counter on edge
  always_ff @(posedge pclk) begin
    if (cap_release) begin
      capture_q <= pending_value_q;
    end else if (cap_take) begin
      capture_q <= counter_q;
    end
  end

  // ----------------------------------------------------------------
  // Counter low-byte latch
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_latched_q <= 1'b0;
      low_latch_q   <= 8'h00;
    end else if (rd_acc && sel_cnth && !low_latched_q) begin
      low_latched_q <= 1'b1;
      low_latch_q   <= counter_q[7:0];
    end else if (rd_acc && sel_cntl) begin
      low_latched_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  flags_type set_ev;
  flags_type clr_ev;
  flags_type seen;

  // R16: capture sets flag
  assign set_ev.capture_event_flag = cap_take || cap_release;
  // R17: equality sets flag
  assign set_ev.compare_match_flag = match;
  // R18: rollover sets flag
  assign set_ev.counter_wrap_flag  = wrap;

  assign seen.capture_event_flag = prdata_q[FLG_CAPTURE_BIT];
  assign seen.compare_match_flag = prdata_q[FLG_COMPARE_BIT];
  assign seen.counter_wrap_flag  = prdata_q[FLG_WRAP_BIT];

  // R16: capture low read clears
  assign clr_ev.capture_event_flag = armed_q.capture_event_flag && rd_acc && sel_capl;
  // R5: compare low access clears
  assign clr_ev.compare_match_flag = armed_q.compare_match_flag && access && sel_cmpl;
  // R18: counter low access clears
  assign clr_ev.counter_wrap_flag  = armed_q.counter_wrap_flag && access && sel_cntl;

  // Status read arms only flags it saw set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= '0;
    end else if (rd_acc && sel_flg) begin
      armed_q <= seen;
    end else begin
      armed_q <= armed_q & ~clr_ev;
    end
  end

  // R15: flags ignore reset and writes
  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk) begin
    flags_q <= set_ev | (flags_q & ~clr_ev);
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  logic irq_d;
  // R9: capture gate
  // R25: wrap gate
  // R26: OR of gated flags
  assign irq_d = (flags_q.capture_event_flag && ctrl_q.capture_irq_enable) ||
                 (flags_q.compare_match_flag && ctrl_q.compare_irq_enable) ||
                 (flags_q.counter_wrap_flag  && ctrl_q.wrap_irq_enable);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // APB read mux and answer
  // ----------------------------------------------------------------
  logic [7:0] ctl_view;
  logic [7:0] flg_view;
  logic [7:0] rd_byte;

  // R27: chosen bit layout
  assign ctl_view = {ctrl_q.capture_irq_enable, ctrl_q.compare_irq_enable,
                     ctrl_q.wrap_irq_enable, 3'h0, edge_select_q,
                     ctrl_q.compare_output_level};
  assign flg_view = {flags_q, 5'h00};

  assign rd_byte = sel_ctl  ? ctl_view :
                   sel_flg  ? flg_view :
                   sel_caph ? capture_q[15:8] :
                   sel_capl ? capture_q[7:0] :
                   sel_cmph ? compare_q[15:8] :
                   sel_cmpl ? compare_q[7:0] :
                   sel_cnth ? counter_q[15:8] :
                   sel_cntl ? (low_latched_q ? low_latch_q : counter_q[7:0]) :
                   8'h00;

  // No wait state: data settles in setup, answered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pready_q  <= 1'b1;
      prdata_q  <= {24'h000000, rd_byte};
      pslverr_q <= !sel_any;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign pready             = pready_q;
  assign prdata             = prdata_q;
  assign pslverr            = pslverr_q;
  assign compare_output_pin = pin_q;
  assign timer_irq          = irq_q;

endmodule : timer_output_compare_status

// ### tb/timer_ocs_sva.sv
// Purpose: Port-level checks of the timer compare/status block
// Assumes: One clock domain; control mirrored from finished writes
// Notes:   Level changes near a match are avoided by the bench
`timescale 1ns/1ps
module timer_ocs_sva
  import timer_pkg::*;
(
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [timer_pkg::ADDR_W+1:0]  paddr,
  input wire logic [31:0]                   pwdata,
  input wire logic                          pready,
  input wire logic [31:0]                   prdata,
  input wire logic                          pslverr,
  input wire logic                          compare_output_pin,
  input wire logic                          timer_irq
);
  logic [7:0] idx;
  logic       ctl_wr;
  logic       in_map;
  logic [3:0] ctl_q;
  assign idx    = paddr[9:2];
  assign ctl_wr = psel && penable && pready && pwrite && idx == IDX_TIMER_CONTROL;
  assign in_map = idx >= IDX_TIMER_CONTROL && idx <= IDX_COUNTER_LOW && paddr[1:0] == 2'h0;
  // Enables and level, as reset leaves them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 4'h0;
    end else if (ctl_wr) begin
      ctl_q <= {pwdata[7:5], pwdata[0]};
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence quiet_s;
    ctl_q[3:1] == 3'h0 ##1 ctl_q[3:1] == 3'h0;
  endsequence
  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  a_err_unmapped: assert property (pready && !in_map |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (pready && in_map |-> !pslverr)
    else $error("mapped access refused");
  a_ctl_readback: assert property (pready && !pwrite && idx == IDX_TIMER_CONTROL |->
    {prdata[7:5], prdata[0]} == ctl_q) else $error("control read differs");
  a_pin_level: assert property ($changed(compare_output_pin) |->
    compare_output_pin == ctl_q[0]) else $error("pin not at level");
  a_irq_masked: assert property (quiet_s |-> !timer_irq)
    else $error("irq with all enables off");
endmodule : timer_ocs_sva

// ### tb/timer_pin_partner.sv
// Purpose: Capture sources seen by the timer from outside
// Assumes: Bench asks for levels; partner launches them on pclk
// Notes:   Both lines are push-pull and always driven
`timescale 1ns/1ps
module timer_pin_partner (
  input  wire logic pclk,
  input  wire logic pin_want,
  input  wire logic cmp_want,
  output logic      capture_input_pin,
  output logic      comparator_two_flag
);
  always @(posedge pclk) begin
    capture_input_pin   <= pin_want;
    comparator_two_flag <= cmp_want;
  end
endmodule : timer_pin_partner

// ### tb/timer_output_compare_status_bench.sv
// Purpose: Self-checking bench of the timer compare/status block
// Assumes: APB master here, pin sources in the partner
// Notes:   Flags start unknown, so each check masks one bit
`timescale 1ns/1ps
module timer_output_compare_status_bench;
  import timer_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, stop_mode, from_cmp;
  logic        pin_want, cmp_want, pready, pslverr, cap_pin, cmp_flag, pin, irq;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          num_errors, comparisons;
  timer_output_compare_status i_timer_output_compare_status (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .stop_mode(stop_mode), .capture_from_comparator(from_cmp),
    .capture_input_pin(cap_pin), .comparator_two_flag(cmp_flag),
    .compare_output_pin(pin), .timer_irq(irq));
  timer_pin_partner i_timer_pin_partner (.pclk(pclk), .pin_want(pin_want),
    .cmp_want(cmp_want), .capture_input_pin(cap_pin), .comparator_two_flag(cmp_flag));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] g, x);
    comparisons++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ix, d, output logic [7:0] q,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk({15'h0, pready}, 16'h0001);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] ix, d);
    logic [7:0] q;
    logic       e;
    apb(1'b1, ix, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] ix, output logic [7:0] q);
    logic e;
    apb(1'b0, ix, 8'h00, q, e);
  endtask : rd
  task automatic rchk(input logic [7:0] ix, m, x);
    logic [7:0] q;
    rd(ix, q);
    chk({8'h0, q & m}, {8'h0, x});
  endtask : rchk
  task automatic cnt_rd(output logic [15:0] c);
    rd(IDX_COUNTER_HIGH, c[15:8]);
    rd(IDX_COUNTER_LOW, c[7:0]);
  endtask : cnt_rd
  task automatic chk_irq(input logic v);
    repeat (2) @(posedge pclk);
    chk({15'h0, irq}, {15'h0, v});
  endtask : chk_irq
  task automatic wait_pin(input logic v);
    int n;
    n = 0;
    while (pin !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk({15'h0, pin}, {15'h0, v});
  endtask : wait_pin
  // Target twelve ticks ahead; arm reads status before the low byte
  task automatic set_cmp(input logic lvl, arm);
    logic [15:0] c;
    logic [7:0]  q;
    wr(IDX_TIMER_CONTROL, {7'h0, lvl});
    cnt_rd(c);
    c = c + 16'd12;
    wr(IDX_COMPARE_HIGH, c[15:8]);
    if (arm) begin
      rd(IDX_EVENT_FLAGS, q);
    end
    wr(IDX_COMPARE_LOW, c[7:0]);
  endtask : set_cmp
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_keep;
    logic [7:0]  q;
    logic        e;
    logic [15:0] c;
    wr(IDX_COMPARE_HIGH, 8'ha5);
    wr(IDX_COMPARE_LOW, 8'h5a);
    wr(IDX_TIMER_CONTROL, 8'he3);
    rchk(IDX_TIMER_CONTROL, 8'he3, 8'he3);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cnt_rd(c);
    chk(c & 16'hfffc, COUNTER_RESET);
    rchk(IDX_TIMER_CONTROL, 8'he3, 8'h02);
    rchk(IDX_COMPARE_HIGH, 8'hff, 8'ha5);
    rchk(IDX_COMPARE_LOW, 8'hff, 8'h5a);
    apb(1'b0, 8'h30, 8'h00, q, e);
    chk({7'h0, e, q}, 16'h0100);
    repeat (24) @(posedge pclk);
    rchk(IDX_EVENT_FLAGS, 8'h20, 8'h20);
  endtask : t_keep
  task automatic t_wrap;
    logic [7:0] q;
    wr(IDX_TIMER_CONTROL, 8'h20);
    chk_irq(1'b1);
    wr(IDX_EVENT_FLAGS, 8'h00);
    rchk(IDX_EVENT_FLAGS, 8'h20, 8'h20);
    rd(IDX_COUNTER_LOW, q);
    rchk(IDX_EVENT_FLAGS, 8'h20, 8'h00);
    chk_irq(1'b0);
  endtask : t_wrap
  task automatic t_compare;
    logic [7:0] q;
    set_cmp(1'b1, 1'b1);
    wait_pin(1'b1);
    rchk(IDX_EVENT_FLAGS, 8'h40, 8'h40);
    rd(IDX_COMPARE_LOW, q);
    rchk(IDX_EVENT_FLAGS, 8'h40, 8'h00);
  endtask : t_compare
  task automatic t_inhibit;
    logic [15:0] c;
    wr(IDX_TIMER_CONTROL, 8'h00);
    cnt_rd(c);
    c = c + 16'd12;
    wr(IDX_COMPARE_LOW, c[7:0]);
    wr(IDX_COMPARE_HIGH, c[15:8]);
    repeat (80) @(posedge pclk);
    chk({15'h0, pin}, 16'h0001);
    set_cmp(1'b0, 1'b0);
    wait_pin(1'b0);
    set_cmp(1'b1, 1'b0);
    wait_pin(1'b1);
    wr(IDX_TIMER_CONTROL, 8'h41);
    chk_irq(1'b1);
    rchk(IDX_EVENT_FLAGS, 8'h40, 8'h40);
    wr(IDX_COMPARE_LOW, 8'h00);
    chk_irq(1'b0);
  endtask : t_inhibit
  task automatic t_capture;
    logic [7:0] q;
    wr(IDX_TIMER_CONTROL, 8'h82);
    pin_want <= 1'b1;
    repeat (8) @(posedge pclk);
    chk_irq(1'b1);
    rchk(IDX_EVENT_FLAGS, 8'h80, 8'h80);
    rd(IDX_CAPTURE_HIGH, q);
    rd(IDX_CAPTURE_LOW, q);
    rchk(IDX_EVENT_FLAGS, 8'h80, 8'h00);
    pin_want <= 1'b0;
    repeat (8) @(posedge pclk);
    rchk(IDX_EVENT_FLAGS, 8'h80, 8'h00);
    wr(IDX_TIMER_CONTROL, 8'h00);
    from_cmp <= 1'b1;
    cmp_want <= 1'b1;
    repeat (8) @(posedge pclk);
    rchk(IDX_EVENT_FLAGS, 8'h80, 8'h00);
    cmp_want <= 1'b0;
    repeat (8) @(posedge pclk);
    rchk(IDX_EVENT_FLAGS, 8'h80, 8'h80);
    chk_irq(1'b0);
    rd(IDX_CAPTURE_LOW, q);
    wr(IDX_TIMER_CONTROL, 8'h02);
    cmp_want <= 1'b1;
    repeat (8) @(posedge pclk);
    rchk(IDX_EVENT_FLAGS, 8'h80, 8'h80);
    rd(IDX_CAPTURE_LOW, q);
  endtask : t_capture
  task automatic t_stop;
    logic [15:0] a, b;
    wr(IDX_TIMER_CONTROL, 8'h02);
    from_cmp <= 1'b0;
    stop_mode <= 1'b1;
    cnt_rd(a);
    repeat (40) @(posedge pclk);
    cnt_rd(b);
    chk(b, a);
    pin_want <= 1'b1;
    repeat (8) @(posedge pclk);
    rchk(IDX_EVENT_FLAGS, 8'h80, 8'h00);
    stop_mode <= 1'b0;
    repeat (8) @(posedge pclk);
    rchk(IDX_EVENT_FLAGS, 8'h80, 8'h80);
    rd(IDX_CAPTURE_HIGH, b[15:8]);
    rd(IDX_CAPTURE_LOW, b[7:0]);
    chk(b, a);
  endtask : t_stop
  task automatic finish_test;
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    {psel, penable, pwrite, stop_mode, from_cmp, pin_want, cmp_want} = 7'h00;
    presetn = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_keep();
    t_wrap();
    t_compare();
    t_inhibit();
    t_capture();
    t_stop();
    finish_test();
  end
  // Whole run is near five hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    finish_test();
  end
endmodule : timer_output_compare_status_bench

bind timer_output_compare_status timer_ocs_sva i_timer_ocs_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .compare_output_pin(compare_output_pin), .timer_irq(timer_irq));
